//--- shared/flow_pkg.sv
/*
  Shared constants and types for the program-flow branch and skip unit.
  Assumes one 50 MHz core clock and a 32-bit APB register port.
*/
// Functional notes
// RQ1: A pointer call pushes the return address, loads the PC from the 16-bit pointer, takes 3 cycles and leaves flags alone.
// RQ2: An equal compare-skip skips the next instruction (PC + 2 or 3) when both registers match, flags unchanged.
// RQ3: An immediate compare subtracts the constant from the register, stores nothing and updates Z, N, V, C and H.
// RQ4: A register bit-clear skip skips the next instruction (PC + 2 or 3) when the chosen bit is 0.
// RQ5: An I/O bit-set skip skips the next instruction (PC + 2 or 3) when the chosen I/O bit is 1, flags unchanged.
// RQ6: A flag-set branch loads PC + offset + 1 when the chosen status bit is 1, else runs on.
// RQ7: A flag-clear branch loads PC + offset + 1 when the chosen status bit is 0, flags unchanged.
// RQ8: The relative offset is sign-extended before it is added to the PC.
package flow_pkg;

  // ****************************************************************
  // Operations issued by the core
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_NONE         = 3'h0,
    OP_PTR_CALL     = 3'h1,
    OP_EQ_SKIP      = 3'h2,
    OP_IMM_CMP      = 3'h3,
    OP_REG_CLR_SKIP = 3'h4,
    OP_IO_SET_SKIP  = 3'h5,
    OP_FLAG_SET_BR  = 3'h6,
    OP_FLAG_CLR_BR  = 3'h7
  } op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CALL = 1'b1
  } state_t;

  // ****************************************************************
  // Timing and step sizes
  // ****************************************************************
  localparam logic [1:0]  CALL_CYCLES = 2'h3;
  localparam logic [1:0]  CALL_WAIT   = CALL_CYCLES - 2'h2;
  localparam logic [15:0] STEP_ONE    = 16'h0001;
  localparam logic [15:0] STEP_SHORT  = 16'h0002;
  localparam logic [15:0] STEP_LONG   = 16'h0003;

  // ****************************************************************
  // Status flag bit positions
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;

  // ****************************************************************
  // Register map (byte addresses) and fields
  // ****************************************************************
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_FLAGS = 8'h04;
  localparam logic [7:0]  ADDR_PC    = 8'h08;
  localparam logic [7:0]  ADDR_STAT  = 8'h0c;
  localparam int          CTRL_EN    = 0;
  localparam int          STAT_BUSY  = 0;
  localparam int          STAT_SKIP  = 1;
  localparam int          STAT_BR    = 2;
  localparam logic        RST_EN     = 1'b1;
  localparam logic [7:0]  RST_FLAGS  = 8'h00;
  localparam logic [15:0] RST_PC     = 16'h0000;

endpackage

//--- src/cmp_sub.sv
/*
  Eight-bit compare subtractor: a - b, result discarded, flags out.
  Assumes purely combinational use by the flow unit.
*/
`timescale 1ns/10ps
module cmp_sub
  import flow_pkg::*;
(
  // Operands
  input  wire logic [7:0] a_in,
  input  wire logic [7:0] b_in,
  // Flags of the subtraction
  output logic            z_out,
  output logic            n_out,
  output logic            v_out,
  output logic            c_out,
  output logic            h_out
);

  logic [7:0] diff;

  // Subtract and derive flags; nothing is written back
  always_comb
  begin
    diff  = a_in - b_in;                                 // see RQ3
    z_out = (diff == 8'h00);
    n_out = diff[7];
    v_out = (a_in[7] & ~b_in[7] & ~diff[7]) | (~a_in[7] & b_in[7] & diff[7]);
    c_out = (~a_in[7] & b_in[7]) | (b_in[7] & diff[7]) | (diff[7] & ~a_in[7]);
    h_out = (~a_in[3] & b_in[3]) | (b_in[3] & diff[3]) | (diff[3] & ~a_in[3]);
  end

endmodule

//--- src/flow_unit.sv
/*
  Program-flow unit: pointer call, compare-skip, immediate compare,
  bit skips and flag branches, plus an APB register port.
  Assumes the core fetch logic presents operands on the same clock and
  holds an operation until issue_ready_out is high.
*/
`timescale 1ns/10ps
module flow_unit
  import flow_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Operation issue from the core
  input  wire logic        issue_valid_in,
  input  wire op_t         op_in,
  input  wire logic [7:0]  rd_val_in,
  input  wire logic [7:0]  rr_val_in,
  input  wire logic [7:0]  imm_in,
  input  wire logic [7:0]  io_val_in,
  input  wire logic [2:0]  bit_sel_in,
  input  wire logic [6:0]  offset_in,
  input  wire logic [15:0] pointer_in,
  input  wire logic        next_long_in,
  output logic             issue_ready_out,
  // Program counter, stack push and flags
  output logic [15:0]      pc_out,
  output logic             push_valid_out,
  output logic [15:0]      push_addr_out,
  output logic [7:0]       status_flags_out,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);

  typedef struct packed {
    state_t      st;
    logic [1:0]  cnt;
    logic [15:0] pc;
    logic [15:0] target;
    logic [7:0]  flags;
    logic        en;
    logic        skip_hit;
    logic        br_hit;
    logic        push_v;
    logic [15:0] push_a;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } unit_state_t;

  unit_state_t s_reg;
  unit_state_t s_next;

  logic        cz;
  logic        cn;
  logic        cv;
  logic        cc;
  logic        ch;
  logic        issue;
  logic [15:0] skip_pc;
  logic [15:0] br_pc;
  logic        wr_go;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Address decode shared by reads and writes
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_CTRL) || (a == ADDR_FLAGS) ||
              (a == ADDR_PC) || (a == ADDR_STAT);
  endfunction

  cmp_sub u_cmp (
    .a_in  (rd_val_in),
    .b_in  (imm_in),
    .z_out (cz),
    .n_out (cn),
    .v_out (cv),
    .c_out (cc),
    .h_out (ch)
  );

  // Issue handshake; disabled unit or a running call refuses
  assign issue_ready_out = s_reg.en && (s_reg.st == ST_IDLE);
  assign issue           = issue_valid_in && issue_ready_out;

  // Skip past a one- or two-word follower
  assign skip_pc = s_reg.pc + (next_long_in ? STEP_LONG : STEP_SHORT);
  // Offset widened with its sign so backward targets work
  assign br_pc = s_reg.pc + {{9{offset_in[6]}}, offset_in} + STEP_ONE; // see RQ8

  // Write lands only on the edge that completes the access
  assign wr_go = psel_in && penable_in && pwrite_in && s_reg.ack &&
                 !s_reg.err;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    s_next        = s_reg;
    s_next.push_v = 1'b0;
    // APB: one wait cycle so read data comes from a flop
    s_next.ack    = psel_in && penable_in && !s_reg.ack;
    s_next.err    = !addr_ok(paddr_in);
    s_next.rdata  = 32'h0000_0000;
    unique case (paddr_in)
      ADDR_CTRL:  s_next.rdata[CTRL_EN] = s_reg.en;
      ADDR_FLAGS: s_next.rdata[7:0] = s_reg.flags;
      ADDR_PC:    s_next.rdata[15:0] = s_reg.pc;
      ADDR_STAT:
      begin
        s_next.rdata[STAT_BUSY] = (s_reg.st == ST_CALL);
        s_next.rdata[STAT_SKIP] = s_reg.skip_hit;
        s_next.rdata[STAT_BR]   = s_reg.br_hit;
      end
      default:    s_next.rdata = 32'h0000_0000;
    endcase
    if (wr_go)
    begin
      unique case (paddr_in)
        ADDR_CTRL:  s_next.en = pwdata_in[CTRL_EN];
        ADDR_FLAGS: s_next.flags = pwdata_in[7:0];
        ADDR_PC:    s_next.pc = pwdata_in[15:0];
        default:    s_next.en = s_reg.en;
      endcase
    end
    // Core side; an executing operation wins over a software write
    unique case (s_reg.st)
      ST_IDLE:
      begin
        if (issue)
        begin
          s_next.skip_hit = 1'b0;
          s_next.br_hit   = 1'b0;
          s_next.pc       = s_reg.pc + STEP_ONE;
          unique case (op_in)
            OP_PTR_CALL:
            begin
              s_next.push_v = 1'b1;                      // see RQ1
              s_next.push_a = s_reg.pc + STEP_ONE;       // see RQ1
              s_next.target = pointer_in;
              s_next.pc     = s_reg.pc;
              s_next.cnt    = CALL_WAIT;
              s_next.st     = ST_CALL;
            end
            OP_EQ_SKIP:
            begin
              if (rd_val_in == rr_val_in)                // see RQ2
              begin
                s_next.pc       = skip_pc;
                s_next.skip_hit = 1'b1;
              end
            end
            OP_IMM_CMP:
            begin
              s_next.flags[FLAG_Z] = cz;                 // see RQ3
              s_next.flags[FLAG_N] = cn;
              s_next.flags[FLAG_V] = cv;
              s_next.flags[FLAG_C] = cc;
              s_next.flags[FLAG_H] = ch;
            end
            OP_REG_CLR_SKIP:
            begin
              if (!rd_val_in[bit_sel_in])                // see RQ4
              begin
                s_next.pc       = skip_pc;
                s_next.skip_hit = 1'b1;
              end
            end
            OP_IO_SET_SKIP:
            begin
              if (io_val_in[bit_sel_in])                 // see RQ5
              begin
                s_next.pc       = skip_pc;
                s_next.skip_hit = 1'b1;
              end
            end
            OP_FLAG_SET_BR:
            begin
              if (s_reg.flags[bit_sel_in])               // see RQ6
              begin
                s_next.pc     = br_pc;
                s_next.br_hit = 1'b1;
              end
            end
            OP_FLAG_CLR_BR:
            begin
              if (!s_reg.flags[bit_sel_in])              // see RQ7
              begin
                s_next.pc     = br_pc;
                s_next.br_hit = 1'b1;
              end
            end
            OP_NONE:    s_next.pc = s_reg.pc;
          endcase
        end
      end
      ST_CALL:
      begin
        // Issue cycle plus two more make the three-cycle call
        if (s_reg.cnt == 2'h0)
        begin
          s_next.pc = s_reg.target;                      // see RQ1
          s_next.st = ST_IDLE;
        end
        else
        begin
          s_next.cnt = s_reg.cnt - 2'h1;
        end
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_reg       <= '0;
      s_reg.st    <= ST_IDLE;
      s_reg.en    <= RST_EN;
      s_reg.flags <= RST_FLAGS;
      s_reg.pc    <= RST_PC;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops, except pslverr_out, which gates err with ack, and issue_ready_out, decoded from en and st above
  assign pc_out           = s_reg.pc;
  assign push_valid_out   = s_reg.push_v;
  assign push_addr_out    = s_reg.push_a;
  assign status_flags_out = s_reg.flags;
  assign prdata_out       = s_reg.rdata;
  assign pready_out       = s_reg.ack;
  assign pslverr_out      = s_reg.ack && s_reg.err;

endmodule

//--- testbench/flow_unit_props.sv
/*
  Checker on the core side of the flow unit.
  Assumes a bind onto flow_unit and one clock domain.
*/
`timescale 1ns/10ps
module flow_unit_props
  import flow_pkg::*;
(
  // Watched ports
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        issue_valid_in,
  input wire op_t         op_in,
  input wire logic [7:0]  rd_val_in,
  input wire logic [7:0]  imm_in,
  input wire logic [7:0]  rr_val_in,
  input wire logic [7:0]  io_val_in,
  input wire logic [2:0]  bit_sel_in,
  input wire logic [6:0]  offset_in,
  input wire logic [15:0] pointer_in,
  input wire logic        next_long_in,
  input wire logic        issue_ready_out,
  input wire logic [15:0] pc_out,
  input wire logic        push_valid_out,
  input wire logic [15:0] push_addr_out,
  input wire logic [7:0]  status_flags_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // ******
  // Take strobe and step sizes
  // ******
  wire logic        tk = issue_valid_in & issue_ready_out;
  wire logic [15:0] sk = next_long_in ? STEP_LONG : STEP_SHORT;
  // Offset widened with its sign so backward targets work
  wire logic [15:0] br = {{9{offset_in[6]}}, offset_in} + STEP_ONE;
  // ******
  // Assertions
  // ******
  chk_call_push: assert property (
    tk && op_in == OP_PTR_CALL |=> push_valid_out
      && push_addr_out == $past(pc_out) + STEP_ONE)
    else $error("bad call push");
  chk_call_busy: assert property (
    tk && op_in == OP_PTR_CALL |=> !issue_ready_out [*2] ##1 issue_ready_out)
    else $error("bad call busy span");
  chk_call_target: assert property (
    tk && op_in == OP_PTR_CALL |-> ##3 pc_out == $past(pointer_in, 3))
    else $error("bad call target");
  chk_eq_skip: assert property (
    tk && op_in == OP_EQ_SKIP && rd_val_in == rr_val_in
      |=> pc_out == $past(pc_out) + $past(sk))
    else $error("bad equal skip");
  chk_clr_skip: assert property (
    tk && op_in == OP_REG_CLR_SKIP && !rd_val_in[bit_sel_in]
      |=> pc_out == $past(pc_out) + $past(sk))
    else $error("bad bit clear skip");
  chk_io_skip: assert property (
    tk && op_in == OP_IO_SET_SKIP && io_val_in[bit_sel_in]
      |=> pc_out == $past(pc_out) + $past(sk))
    else $error("bad io skip");
  chk_set_branch: assert property (
    tk && op_in == OP_FLAG_SET_BR && status_flags_out[bit_sel_in]
      |=> pc_out == $past(pc_out) + $past(br))
    else $error("bad set branch");
  chk_clr_branch: assert property (
    tk && op_in == OP_FLAG_CLR_BR && !status_flags_out[bit_sel_in]
      |=> pc_out == $past(pc_out) + $past(br))
    else $error("bad clear branch");
  // Zero and borrow worked out from the operands, not the subtractor
  chk_cmp_flags: assert property (
    tk && op_in == OP_IMM_CMP
      |=> status_flags_out[FLAG_Z] == ($past(rd_val_in) == $past(imm_in))
      && status_flags_out[FLAG_C] == ($past(rd_val_in) < $past(imm_in)))
    else $error("bad compare flags");
endmodule
bind flow_unit flow_unit_props props (.*);

//--- testbench/core_model.sv
/*
  Core-side model: offers operations to the flow unit.
  Assumes rising-edge sampling; operands come packed in 59 bits.
*/
`timescale 1ns/10ps
module core_model
  import flow_pkg::*;
(
  // Clock and handshake
  input  wire logic   core_clk_in,
  input  wire logic   issue_ready_out,
  output logic        issue_valid_in,
  // Operation and operands
  output op_t         op_in,
  output logic [7:0]  rd_val_in,
  output logic [7:0]  rr_val_in,
  output logic [7:0]  imm_in,
  output logic [7:0]  io_val_in,
  output logic [2:0]  bit_sel_in,
  output logic [6:0]  offset_in,
  output logic [15:0] pointer_in,
  output logic        next_long_in
);
  // ******
  // Operand bus and issue task
  // ******
  logic [58:0] f;
  assign {rd_val_in, rr_val_in, imm_in, io_val_in, bit_sel_in,
          offset_in, pointer_in, next_long_in} = f;
  initial
  begin
    issue_valid_in = 1'b0;
    op_in          = OP_NONE;
    f              = '0;
  end
  // Hold until taken; released lines show the inverse, not stale data
  task automatic issue(input op_t o, input logic [58:0] v);
    @(posedge core_clk_in);
    issue_valid_in <= 1'b1;
    op_in          <= o;
    f              <= v;
    do
      @(posedge core_clk_in);
    while (issue_ready_out !== 1'b1);
    issue_valid_in <= 1'b0;
    f              <= ~v;
  endtask
endmodule

//--- testbench/program_flow_branch_skip_unit_tb.sv
/*
  Testbench: core operations and register port of the flow unit.
  Assumes core_model and the checker are compiled first.
*/
`timescale 1ns/10ps
module program_flow_branch_skip_unit_tb
  import flow_pkg::*;
;
  // ******
  // Signals, clock and instances
  // ******
  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic        issue_valid_in, issue_ready_out, next_long_in;
  op_t         op_in;
  logic [7:0]  rd_val_in, rr_val_in, imm_in, io_val_in;
  logic [7:0]  status_flags_out;
  logic [2:0]  bit_sel_in;
  logic [6:0]  offset_in;
  logic [15:0] pointer_in, pc_out, push_addr_out;
  logic        push_valid_out, pready_out, pslverr_out, er;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  int          failures = 0, total_checks = 0;
  always #10 core_clk_in = ~core_clk_in;
  flow_unit  dut (.*);
  core_model cm (.*);
  // ******
  // Tasks
  // ******
  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do
      @(posedge core_clk_in);
    while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // Operand order: rd rr imm io, bit offset, pointer long
  task automatic op(input op_t o, input logic [58:0] v,
                    input logic [15:0] e);
    cm.issue(o, v);
    #1 check(pc_out, e);
  endtask
  task automatic results();
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ******
  // Tests
  // ******
  initial
  begin
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], er}, 32'h1);
    apb(1'b1, ADDR_PC, 32'h100);
    op(OP_IMM_CMP, {32'h10002100, 10'h0, 17'h0}, 16'h0101);
    check(status_flags_out, 32'h25);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(rd, 32'h25);
    op(OP_IMM_CMP, {32'h80000100, 10'h0, 17'h0}, 16'h0102);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(rd, 32'h28);
    op(OP_EQ_SKIP, {32'h5a5a0000, 10'h0, 17'h1}, 16'h0105);
    op(OP_EQ_SKIP, {32'h5a5b0000, 10'h0, 17'h0}, 16'h0106);
    op(OP_REG_CLR_SKIP, {32'h7f000000, 10'h380, 17'h1}, 16'h0109);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd, 32'h2);
    op(OP_REG_CLR_SKIP, {32'h01000000, 10'h0, 17'h0}, 16'h010a);
    op(OP_IO_SET_SKIP, {32'h80, 10'h380, 17'h0}, 16'h010c);
    op(OP_IO_SET_SKIP, {32'h7f, 10'h380, 17'h0}, 16'h010d);
    op(OP_FLAG_SET_BR, {32'h0, 10'h1fe, 17'h0}, 16'h010c);
    op(OP_FLAG_SET_BR, {32'h0, 10'h17e, 17'h0}, 16'h010d);
    op(OP_FLAG_CLR_BR, {32'h0, 10'h03f, 17'h0}, 16'h014d);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(rd, 32'h4);
    op(OP_FLAG_CLR_BR, {32'h0, 10'h2bf, 17'h0}, 16'h014e);
    cm.issue(OP_PTR_CALL, {32'h0, 10'h0, 16'h2345, 1'b0});
    #1 check({push_valid_out, issue_ready_out, push_addr_out}, 18'h2014f);
    repeat (2) @(posedge core_clk_in);
    #1 check(pc_out, 16'h2345);
    // An empty operation leaves the PC where it is
    op(OP_NONE, 59'h0, 16'h2345);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(rd, 32'h28);
    // Disabled unit refuses issue; write lands on the pready edge
    apb(1'b1, ADDR_CTRL, 32'h0);
    #1 check(issue_ready_out, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    // Reset in mid-run brings PC and enable back to their start
    rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    apb(1'b0, ADDR_PC, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h1);
    results();
  end
  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    #100000;
    failures++;
    results();
  end
endmodule
